// ===== logic/gdmd_pkg.sv
/*
 * gdmd_pkg: constants shared by the gear display message decoder.
 * assumes a 125 MHz clock; the silence and bus-idle times are turned into cycle counts here.
 */
package gdmd_pkg;
    localparam int unsigned CLK_MHZ           = 125;
    localparam logic [7:0]  CTRL_MARK         = 8'h00;
    localparam logic [7:0]  CH_SPACE          = 8'h20;
    localparam logic [7:0]  CH_STAR           = 8'h2a;
    localparam int          ARROW_LSB         = 0;
    localparam int          TONE_LSB          = 2;
    localparam logic [1:0]  TONE_ON_CODE      = 2'h1;
    localparam logic [1:0]  ARROW_RST         = 2'h0;
    localparam int unsigned SILENCE_MS        = 5000;
    localparam int unsigned BUS_IDLE_MS       = 5000;
    localparam int unsigned SHOW_LATENCY_MS   = 75;
    localparam int unsigned KEYON_READY_MS    = 2000;
    localparam int unsigned SILENCE_CYC       = SILENCE_MS * CLK_MHZ * 1000;
    localparam int unsigned BUS_IDLE_CYC      = BUS_IDLE_MS * CLK_MHZ * 1000;
    localparam logic [7:0]  CH_R              = 8'h52;
    localparam logic [7:0]  CH_C              = 8'h43;
    localparam logic [7:0]  CH_P              = 8'h50;
    localparam logic [7:0]  CH_S              = 8'h53;
    localparam logic [7:0]  CH_G              = 8'h47;
    localparam logic [7:0]  CH_ONE            = 8'h31;
    localparam logic [7:0]  CH_TWO            = 8'h32;
    localparam logic [7:0]  CH_ZERO           = 8'h30;
    localparam logic [7:0]  CH_FOUR           = 8'h34;
    localparam logic [7:0]  CH_EIGHT          = 8'h38;
    localparam logic [7:0]  CH_NINE           = 8'h39;
    localparam logic [7:0]  CH_A              = 8'h41;
    localparam logic [7:0]  CH_T              = 8'h54;
    localparam logic [7:0]  CH_D              = 8'h44;
    localparam logic [7:0]  CH_I              = 8'h49;
    localparam logic [7:0]  CH_N              = 8'h4e;
    localparam logic [7:0]  CH_F              = 8'h46;
    localparam logic [7:0]  CH_L              = 8'h4c;
    localparam logic [7:0]  CH_DASH           = 8'h2d;

    typedef enum logic [2:0] {
        GDMD_NOBUS = 3'b001,
        GDMD_BLANK = 3'b010,
        GDMD_SHOW  = 3'b100
    } gdmd_state_e;
endpackage

// ===== logic/gdmd_timer.sv
/*
 * gdmd_timer: restartable down counter that flags when a span expires.
 * assumes restart is a one-cycle pulse in the clk domain.
 */
`timescale 1ns/100ps
module gdmd_timer #(
    parameter int unsigned SPAN = 1000
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic restart,
    output logic      expired
);
    localparam int W = $clog2(SPAN + 1);

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    // count down from the span; parks at zero so expiry holds as a level
    always_comb begin
        cnt_nxt = cnt_r;
        if (restart) begin
            cnt_nxt = W'(SPAN);
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - W'(1);
        end
    end

    // starts expired so the no-bus view is shown before the first message
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign expired = (cnt_r == '0);
endmodule

// ===== logic/gdmd_decoder.sv
/*
 * gdmd_decoder: turns the two character bytes of the gear display
 * message into two display characters, arrows and an alert tone.
 * assumes a framing block ahead of it presents each received message as
 * a one-cycle msg_valid with both bytes, and raises bus_activity for any
 * frame seen on the link, whatever its content.
 */
`timescale 1ns/100ps
module gdmd_decoder
    import gdmd_pkg::*;
#(
    parameter int unsigned SILENCE_SPAN  = gdmd_pkg::SILENCE_CYC,
    parameter int unsigned BUS_IDLE_SPAN = gdmd_pkg::BUS_IDLE_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       msg_valid,
    input  wire logic [7:0] msg_byte_first,
    input  wire logic [7:0] msg_byte_second,
    input  wire logic       bus_activity,
    output logic [7:0]      disp_left,
    output logic [7:0]      disp_right,
    output logic            disp_on,
    output logic            arrow_up,
    output logic            arrow_down,
    output logic            tone_on
);
    import gdmd_pkg::*;

    // release reset through two flops so the body never sees a runt edge
    logic rst_sync1_r;
    logic rst_sync2_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync1_r <= 1'b0;
            rst_sync2_r <= 1'b0;
        end else begin
            rst_sync1_r <= 1'b1;
            rst_sync2_r <= rst_sync1_r;
        end
    end
    wire logic rst_int_n = rst_sync2_r;

    // true when a character pair is one the display is asked to render
    function automatic logic pair_ok(input logic [7:0] a, input logic [7:0] b);
        logic ok;
        ok = 1'b0;
        if (a == CH_R && b >= CH_ONE && b <= CH_FOUR) ok = 1'b1;
        if (a == CH_SPACE && b >= CH_ONE && b <= CH_NINE) ok = 1'b1;
        if (a == CH_ONE && b >= CH_ZERO && b <= CH_EIGHT) ok = 1'b1;
        if (a == CH_SPACE && (b == CH_N || b == CH_F || b == CH_L ||
                              b == CH_DASH)) ok = 1'b1;
        if (a == CH_C && b == CH_A) ok = 1'b1;
        if (a == CH_S && b == CH_T) ok = 1'b1;
        if (a == CH_P && b == CH_D) ok = 1'b1;
        if (a == CH_G && b == CH_I) ok = 1'b1;
        if (a == CH_P && b == CH_S) ok = 1'b1;
        if (a == CH_C && (b == CH_ONE || b == CH_TWO)) ok = 1'b1;
        return ok;
    endfunction

    // message classification
    logic is_ctrl;
    logic is_chars;
    logic is_bad;
    assign is_ctrl  = msg_valid && (msg_byte_first == CTRL_MARK);
    assign is_chars = msg_valid && !is_ctrl &&
                      pair_ok(msg_byte_first, msg_byte_second);
    assign is_bad   = msg_valid && !is_ctrl && !is_chars;

    // silence timers: one for the message, one for any bus traffic
    logic msg_expired;
    logic bus_expired;
    logic good_msg;
    assign good_msg = is_ctrl || is_chars;

    gdmd_timer #(.SPAN(SILENCE_SPAN)) u_msg_timer (
        .clk     (clk),
        .rst_n   (rst_int_n),
        .restart (good_msg),
        .expired (msg_expired)
    );

    gdmd_timer #(.SPAN(BUS_IDLE_SPAN)) u_bus_timer (
        .clk     (clk),
        .rst_n   (rst_int_n),
        .restart (bus_activity || msg_valid),
        .expired (bus_expired)
    );

    // display state and held characters
    gdmd_state_e state_r;
    gdmd_state_e state_nxt;
    logic [7:0]  left_r;
    logic [7:0]  left_nxt;
    logic [7:0]  right_r;
    logic [7:0]  right_nxt;
    logic [1:0]  arrow_r;
    logic [1:0]  arrow_nxt;
    logic        tone_r;
    logic        tone_nxt;

    // next state; a message acts on the very next edge, far inside 75 ms
    always_comb begin
        state_nxt = state_r;
        left_nxt  = left_r;
        right_nxt = right_r;
        arrow_nxt = arrow_r;
        tone_nxt  = tone_r;
        if (is_chars) begin
            left_nxt  = msg_byte_first;
            right_nxt = msg_byte_second;
            state_nxt = GDMD_SHOW;
        end else if (is_ctrl) begin
            // characters kept as they were
            arrow_nxt = msg_byte_second[ARROW_LSB +: 2];
            // only code 01 sounds; 10, 11 and the top nibble are ignored
            tone_nxt  = (msg_byte_second[TONE_LSB +: 2] == TONE_ON_CODE);
            if (state_r == GDMD_NOBUS) begin
                state_nxt = GDMD_BLANK;
            end
        end else if (is_bad) begin
            state_nxt = GDMD_BLANK;
        end else if (bus_expired) begin
            state_nxt = GDMD_NOBUS;
        end else if (msg_expired) begin
            state_nxt = GDMD_BLANK;
        end
        // silence also kills arrows and tone
        if (!good_msg && (bus_expired || msg_expired)) begin
            arrow_nxt = ARROW_RST;
            tone_nxt  = 1'b0;
        end
    end

    // reset starts in no-bus; output is valid two edges after release
    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            state_r <= GDMD_NOBUS;
            left_r  <= CH_SPACE;
            right_r <= CH_SPACE;
            arrow_r <= ARROW_RST;
            tone_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            left_r  <= left_nxt;
            right_r <= right_nxt;
            arrow_r <= arrow_nxt;
            tone_r  <= tone_nxt;
        end
    end

    // output registers: what the glass shows follows the state
    logic [7:0] dl_r;
    logic [7:0] dl_nxt;
    logic [7:0] dr_r;
    logic [7:0] dr_nxt;
    logic       on_r;
    logic       on_nxt;
    // blank keeps the last glyphs latched, so a control action or a bad
    // frame never rewrites them behind the dark glass
    always_comb begin
        dl_nxt = dl_r;
        dr_nxt = dr_r;
        on_nxt = 1'b0;
        case (state_nxt)
            GDMD_NOBUS: begin
                dl_nxt = CH_STAR;
                dr_nxt = CH_STAR;
                on_nxt = 1'b1;
            end
            GDMD_BLANK: begin
                on_nxt = 1'b0;
            end
            GDMD_SHOW: begin
                dl_nxt = left_nxt;
                dr_nxt = right_nxt;
                on_nxt = 1'b1;
            end
            default: begin
                on_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            dl_r <= CH_STAR;
            dr_r <= CH_STAR;
            on_r <= 1'b1;
        end else begin
            dl_r <= dl_nxt;
            dr_r <= dr_nxt;
            on_r <= on_nxt;
        end
    end

    assign disp_left  = dl_r;
    assign disp_right = dr_r;
    assign disp_on    = on_r;
    assign arrow_up   = arrow_r[0];
    assign arrow_down = arrow_r[1];
    assign tone_on    = tone_r;
endmodule

// ===== bench/gdmd_properties.sv
/* gdmd_properties: port checker for gdmd_decoder.
   assumes it is bound onto the decoder; one clk domain, rst_n low. */
`timescale 1ns/100ps
module gdmd_checker
    import gdmd_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       msg_valid,
    input wire logic [7:0] msg_byte_first,
    input wire logic [7:0] msg_byte_second,
    input wire logic       bus_activity,
    input wire logic [7:0] disp_left,
    input wire logic [7:0] disp_right,
    input wire logic       disp_on,
    input wire logic       arrow_up,
    input wire logic       arrow_down,
    input wire logic       tone_on
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // message kinds; a zero first byte is a control action
    wire ctl = msg_valid && msg_byte_first == CTRL_MARK;
    wire chr = msg_valid && msg_byte_first != CTRL_MARK;
    property p_keep;
        ctl |=> $stable({disp_left, disp_right});
    endproperty
    a_keep: assert property (p_keep) else $error("chars moved");
    property p_up;
        ctl |=> arrow_up == $past(msg_byte_second[0]);
    endproperty
    a_up: assert property (p_up) else $error("up arrow");
    property p_dn;
        ctl |=> arrow_down == $past(msg_byte_second[1]);
    endproperty
    a_dn: assert property (p_dn) else $error("down arrow");
    property p_tone;
        ctl |=> tone_on == ($past(msg_byte_second[3:2]) == TONE_ON_CODE);
    endproperty
    a_tone: assert property (p_tone) else $error("tone");
    property p_char;
        chr |=> !disp_on || {disp_left, disp_right} ==
            $past({msg_byte_first, msg_byte_second});
    endproperty
    a_char: assert property (p_char) else $error("char pair");
    property p_bad;
        chr && msg_byte_second == 8'h00 |=> !disp_on;
    endproperty
    a_bad: assert property (p_bad) else $error("not blanked");
    property p_hold;
        !msg_valid |=> $stable(disp_left) || !disp_on || disp_left == CH_STAR;
    endproperty
    a_hold: assert property (p_hold) else $error("char drift");
    property p_quiet;
        disp_on && disp_left == CH_STAR |->
            !(arrow_up || arrow_down || tone_on);
    endproperty
    a_quiet: assert property (p_quiet) else $error("noisy idle");
endmodule
bind gdmd_decoder gdmd_checker i_gdmd_checker (
    .clk, .rst_n, .msg_valid, .msg_byte_first, .msg_byte_second,
    .bus_activity, .disp_left, .disp_right, .disp_on, .arrow_up,
    .arrow_down, .tone_on
);

// ===== bench/gdmd_partner.sv
/* gdmd_partner: transmission controller model sending display frames.
   assumes tasks are called from the bench in the clk domain. */
`timescale 1ns/100ps
module gdmd_partner (
    input  wire logic  clk,
    output logic       msg_valid,
    output logic [7:0] msg_byte_first,
    output logic [7:0] msg_byte_second,
    output logic       bus_activity
);
    // link idle at power up, byte lines carry junk
    initial begin
        msg_valid = 1'b0;
        bus_activity = 1'b0;
        msg_byte_first = 8'h5a;
        msg_byte_second = 8'ha5;
    end
    // one frame for one edge; bytes inverted after so stale data never
    // looks like a fresh message
    task automatic send(input logic [7:0] f, input logic [7:0] s);
        @(posedge clk);
        msg_valid <= 1'b1;
        bus_activity <= 1'b1;
        msg_byte_first <= f;
        msg_byte_second <= s;
        @(posedge clk);
        msg_valid <= 1'b0;
        bus_activity <= 1'b0;
        msg_byte_first <= ~f;
        msg_byte_second <= ~s;
    endtask
    // a frame of other content: keeps the link alive only
    task automatic ping;
        @(posedge clk);
        bus_activity <= 1'b1;
        @(posedge clk);
        bus_activity <= 1'b0;
    endtask
endmodule

// ===== bench/testbench.sv
/* testbench: self-checking bench for gdmd_decoder.
   assumes shortened timer spans so silence and idle show quickly. */
`timescale 1ns/100ps
module testbench;
    import gdmd_pkg::*;
    // short spans keep the timer scenarios within a few hundred cycles
    localparam int unsigned SIL_SPAN  = 50;
    localparam int unsigned IDLE_SPAN = 200;
    localparam logic [15:0] ODD [11] = '{16'h204e, 16'h2046, 16'h204c,
        16'h202d, 16'h4341, 16'h5354, 16'h5044, 16'h4749, 16'h5053,
        16'h4331, 16'h4332};
    logic       clk;
    logic       rst_n;
    logic       msg_valid;
    logic [7:0] msg_byte_first;
    logic [7:0] msg_byte_second;
    logic       bus_activity;
    logic [7:0] disp_left;
    logic [7:0] disp_right;
    logic       disp_on;
    logic       arrow_up;
    logic       arrow_down;
    logic       tone_on;
    int         errors;
    int         checks_done;
    // 125 MHz
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    gdmd_decoder #(
        .SILENCE_SPAN  (SIL_SPAN),
        .BUS_IDLE_SPAN (IDLE_SPAN)
    ) i_gdmd_decoder (
        .clk, .rst_n, .msg_valid, .msg_byte_first, .msg_byte_second,
        .bus_activity, .disp_left, .disp_right, .disp_on, .arrow_up,
        .arrow_down, .tone_on
    );
    gdmd_partner i_gdmd_partner (
        .clk, .msg_valid, .msg_byte_first, .msg_byte_second, .bus_activity
    );
    function automatic logic [19:0] st();
        return {disp_on, arrow_up, arrow_down, tone_on, disp_left, disp_right};
    endfunction
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // send a character pair and expect it lit one cycle later
    task automatic show(input logic [7:0] f, input logic [7:0] s);
        i_gdmd_partner.send(f, s);
        #1;
        chk({3'h0, disp_on, disp_left, disp_right}, {4'h1, f, s});
    endtask
    task automatic t_table;
        for (int i = 1; i < 5; i++) show(CH_R, CH_ZERO + 8'(i));
        for (int i = 1; i < 10; i++) show(CH_SPACE, CH_ZERO + 8'(i));
        for (int i = 0; i < 9; i++) show(CH_ONE, CH_ZERO + 8'(i));
        for (int i = 0; i < 11; i++) show(ODD[i][15:8], ODD[i][7:0]);
        $display("table done");
    endtask
    // every arrow and tone code, reserved bits both ways
    task automatic t_ctrl;
        show(CH_SPACE, CH_FOUR);
        for (int i = 0; i < 32; i++) begin
            i_gdmd_partner.send(CTRL_MARK, {{4{i[4]}}, i[3:0]});
            #1;
            chk(st(), {1'b1, i[0], i[1], i[3:2] == 2'h1,
                       CH_SPACE, CH_FOUR});
        end
        $display("control done");
    endtask
    task automatic t_bad;
        logic [19:0] was;
        show(CH_C, CH_TWO);
        was = st();
        i_gdmd_partner.send(CH_R, 8'h00);
        #1;
        chk(st(), {1'b0, was[18:0]});
        show(CH_SPACE, CH_N);
        $display("bad char done");
    endtask
    // link stays busy but no display frame: blank after the span
    task automatic t_silence;
        i_gdmd_partner.send(CTRL_MARK, 8'hf7);
        repeat (3) i_gdmd_partner.ping();
        #1;
        chk({16'h0, disp_on, arrow_up, arrow_down, tone_on}, 20'hf);
        // pings only refresh the bus timer; the message timer runs out
        repeat (SIL_SPAN / 2) i_gdmd_partner.ping();
        #1;
        chk({16'h0, disp_on, arrow_up, arrow_down, tone_on}, 20'h0);
        $display("silence done");
    endtask
    task automatic t_nobus;
        repeat (IDLE_SPAN + 30) @(posedge clk);
        #1;
        chk(st(), {4'h8, CH_STAR, CH_STAR});
        // a control action ends the idle view but must not touch the glyphs
        i_gdmd_partner.send(CTRL_MARK, 8'hf1);
        #1;
        chk(st(), {4'h4, CH_STAR, CH_STAR});
        $display("no bus done");
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // hang guard, well past the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        summarize;
    end
    initial begin
        rst_n = 1'b0;
        errors = 0;
        checks_done = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(st(), {4'h8, CH_STAR, CH_STAR});
        t_table;
        t_ctrl;
        t_bad;
        t_silence;
        t_nobus;
        summarize;
    end
endmodule
